// [rtl/uart_core.sv]
`timescale 1ns/1ns
`default_nettype none
module uart_core #(
    parameter int DIV_W = 16
) (
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // serial pins
    input  wire logic        rx_in,
    output logic             tx_out,
    output logic             tx_oe,
    output logic             rx_claim,
    // event
    output logic             tx_irq
);

    // counters and read mux are laid out for a 16-bit divider only
    if (DIV_W != 16)
    begin : g_div_width
        $error("uart_core: divider width must be 16");
    end

    uart_pkg::ctrl_t     ctrl;
    uart_pkg::ctrl_t     next_ctrl;
    logic [DIV_W-1:0]    divisor_value;
    logic [2:0]          frac_adjust_bits;
    logic                divisor_range_sel;
    logic                status_armed;
    logic                tx_buffer_empty_flag;
    logic                tx_idle_flag;
    logic [8:0]          hold_word;
    logic                hold_full;
    uart_pkg::tx_state_t tx_state;
    logic [8:0]          tx_shift_reg;
    logic                tx_par;
    logic [3:0]          tx_idx;
    logic                tx_stop_idx;
    logic [DIV_W:0]      tx_cnt;
    logic [2:0]          tx_acc;
    uart_pkg::rx_state_t rx_state;
    logic                rx_sync_a;
    logic                rx_sync_b;
    logic                rx_sync_c;
    logic                rx_level;
    logic                rx_level_q;
    logic [8:0]          rx_shift;
    logic                rx_par;
    logic [3:0]          rx_idx;
    logic [DIV_W:0]      rx_cnt;
    logic [2:0]          rx_acc;
    logic [8:0]          rx_data;
    logic [2:0]          rx_fill_count;
    logic                rx_data_avail_flag;
    logic                overrun_flag;
    logic                frame_err_flag;
    logic                parity_err_flag;
    logic                noise_flag;
    logic                rx_addr_flag;

    function automatic logic par_bit(input logic [8:0] d, input logic nine, input logic [1:0] typ);
        logic x;
        x = ^(nine ? d : {1'b0, d[7:0]});
        case (typ)
            uart_pkg::PAR_EVEN: par_bit = x;
            uart_pkg::PAR_ODD:  par_bit = ~x;
            uart_pkg::PAR_MARK: par_bit = 1'b1;
            default:            par_bit = 1'b0;
        endcase
    endfunction

    // bus decode
    wire access_done = psel & penable & pready;
    wire wr          = access_done & pwrite;
    wire rd          = access_done & ~pwrite;
    wire sel_ctrl    = paddr == uart_pkg::OFS_CTRL;
    wire sel_stat    = paddr == uart_pkg::OFS_STAT;
    wire sel_data    = paddr == uart_pkg::OFS_DATA;
    wire sel_div     = paddr == uart_pkg::OFS_DIV;
    wire sel_frac    = paddr == uart_pkg::OFS_FRAC;
    wire mapped      = sel_ctrl | sel_stat | sel_data | sel_div | sel_frac;
    wire ro_write    = pwrite & sel_stat;

    uart_pkg::status_t stat;
    assign stat = '{rx_addr_flag, rx_fill_count, noise_flag, parity_err_flag, frame_err_flag, overrun_flag,
                    rx_state == uart_pkg::RX_IDLE, rx_data_avail_flag, tx_idle_flag, tx_buffer_empty_flag};

    wire [31:0] rd_mux = sel_ctrl ? {20'h00000, ctrl} :
                         sel_stat ? {20'h00000, stat} :
                         sel_data ? {23'h000000, rx_data} :
                         sel_div  ? {16'h0000, divisor_value} :
                         sel_frac ? {28'h0000000, divisor_range_sel, frac_adjust_bits} :
                         32'h00000000;

    always_comb
    begin
        next_ctrl = ctrl;
        if (wr && sel_ctrl)
            next_ctrl = uart_pkg::ctrl_t'(pwdata[11:0]);
        if (!next_ctrl.serial_unit_on)
        begin
            next_ctrl.tx_path_enable = 1'b0;
            next_ctrl.rx_path_enable = 1'b0;
            next_ctrl.send_break_ctl = 1'b0;
        end
    end

    // one wait state keeps prdata and pready straight from flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & (~mapped | ro_write);
            if (psel && penable && !pready && !pwrite)
                prdata <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl              <= uart_pkg::CTRL_RST;
            divisor_value     <= uart_pkg::DIV_RST;
            frac_adjust_bits  <= uart_pkg::FRAC_RST;
            divisor_range_sel <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            if (wr && sel_div)
                divisor_value <= pwdata[DIV_W-1:0];
            if (wr && sel_frac)
            begin
                frac_adjust_bits  <= pwdata[2:0];
                divisor_range_sel <= pwdata[3];
            end
        end
    end

    // status read arms the clearing data access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_armed <= 1'b0;
        else if (rd && sel_stat)
            status_armed <= 1'b1;
        else if (access_done && sel_data)
            status_armed <= 1'b0;
    end

    // transmit path; one shared divisor and format serve both directions
    wire       unit_on    = ctrl.serial_unit_on;
    wire       baud_ok    = divisor_value != '0;
    wire       tx_run     = unit_on & ctrl.tx_path_enable & baud_ok;
    wire       data_wr_ok = wr & sel_data & status_armed & tx_buffer_empty_flag & unit_on;
    wire [8:0] wr_word    = {ctrl.word_len_nine & ctrl.tx_ninth_bit, pwdata[7:0]};
    wire       tx_is_idle = tx_state == uart_pkg::TX_IDLE;
    wire       direct     = data_wr_ok & tx_is_idle & tx_run & ~hold_full;
    wire       from_hold  = tx_is_idle & tx_run & hold_full;
    wire       tx_load    = direct | from_hold;
    wire [8:0] load_word  = direct ? wr_word : hold_word;
    wire [3:0] tx_sum     = {1'b0, tx_acc} + {1'b0, frac_adjust_bits};
    wire [DIV_W:0] tx_len = {1'b0, divisor_value} - 17'h00001 + {16'h0000, tx_sum[3]};
    wire       tx_tick    = ~tx_is_idle & (tx_cnt == '0);
    wire [3:0] last_idx   = ctrl.word_len_nine ? 4'h8 : 4'h7;
    wire       frame_done = tx_tick & (tx_state == uart_pkg::TX_STOP) & ~(ctrl.two_stop_sel & ~tx_stop_idx);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_buffer_empty_flag <= 1'b1;
            tx_idle_flag         <= 1'b1;
            hold_full            <= 1'b0;
            hold_word            <= 9'h000;
        end
        else if (!unit_on)
        begin
            tx_buffer_empty_flag <= 1'b1;
            tx_idle_flag         <= 1'b1;
            hold_full            <= 1'b0;
        end
        else
        begin
            if (data_wr_ok && !direct)
            begin
                hold_word            <= wr_word;
                hold_full            <= 1'b1;
                tx_buffer_empty_flag <= 1'b0;
            end
            else if (from_hold)
            begin
                hold_full            <= 1'b0;
                tx_buffer_empty_flag <= 1'b1;
            end
            if (data_wr_ok)
                tx_idle_flag <= 1'b0;
            if (frame_done)
                tx_idle_flag <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_state     <= uart_pkg::TX_IDLE;
            tx_out       <= 1'b1;
            tx_shift_reg <= 9'h000;
            tx_par       <= 1'b0;
            tx_idx       <= 4'h0;
            tx_stop_idx  <= 1'b0;
            tx_cnt       <= '0;
            tx_acc       <= 3'h0;
        end
        else if (!tx_run)
        begin
            tx_state <= uart_pkg::TX_IDLE;
            tx_out   <= 1'b1;
            tx_acc   <= 3'h0;
        end
        else if (tx_load)
        begin
            tx_state     <= uart_pkg::TX_START;
            tx_out       <= 1'b0;
            tx_shift_reg <= load_word;
            tx_par       <= par_bit(load_word, ctrl.word_len_nine, ctrl.parity_type_sel);
            tx_idx       <= 4'h0;
            tx_stop_idx  <= 1'b0;
            tx_cnt       <= tx_len;
            tx_acc       <= tx_sum[2:0];
        end
        else if (tx_tick)
        begin
            tx_cnt <= tx_len;
            tx_acc <= tx_sum[2:0];
            case (tx_state)
                uart_pkg::TX_START:
                begin
                    tx_state <= uart_pkg::TX_DATA;
                    tx_out   <= tx_shift_reg[0];
                end
                uart_pkg::TX_DATA:
                begin
                    if (tx_idx == last_idx)
                    begin
                        tx_state <= ctrl.parity_on ? uart_pkg::TX_PAR : uart_pkg::TX_STOP;
                        tx_out   <= ctrl.parity_on ? tx_par : 1'b1;
                    end
                    else
                    begin
                        tx_idx       <= tx_idx + 4'h1;
                        tx_shift_reg <= {1'b0, tx_shift_reg[8:1]};
                        tx_out       <= tx_shift_reg[1];
                    end
                end
                uart_pkg::TX_PAR:
                begin
                    tx_state <= uart_pkg::TX_STOP;
                    tx_out   <= 1'b1;
                end
                uart_pkg::TX_STOP:
                begin
                    if (ctrl.two_stop_sel && !tx_stop_idx)
                        tx_stop_idx <= 1'b1;
                    else
                        tx_state <= uart_pkg::TX_IDLE;
                end
                default:
                    tx_state <= uart_pkg::TX_IDLE;
            endcase
        end
        else if (!tx_is_idle)
            tx_cnt <= tx_cnt - {{DIV_W{1'b0}}, 1'b1};
    end

    // receive path: three flops, level changes once the last two agree
    wire       rx_run   = unit_on & ctrl.rx_path_enable & baud_ok;
    wire [3:0] rx_sum   = {1'b0, rx_acc} + {1'b0, frac_adjust_bits};
    wire [DIV_W:0] rx_len = {1'b0, divisor_value} - 17'h00001 + {16'h0000, rx_sum[3]};
    wire       rx_tick  = (rx_state != uart_pkg::RX_IDLE) & (rx_cnt == '0);
    wire [8:0] rx_word  = ctrl.word_len_nine ? rx_shift : {1'b0, rx_shift[8:1]};
    wire       rx_msb   = ctrl.word_len_nine ? rx_shift[8] : rx_shift[8];
    wire       rx_clear = rd & sel_data & status_armed;
    wire       rx_done  = rx_tick & (rx_state == uart_pkg::RX_STOP);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_sync_a  <= 1'b1;
            rx_sync_b  <= 1'b1;
            rx_sync_c  <= 1'b1;
            rx_level   <= 1'b1;
            rx_level_q <= 1'b1;
        end
        else
        begin
            rx_sync_a  <= rx_in;
            rx_sync_b  <= rx_sync_a;
            rx_sync_c  <= rx_sync_b;
            rx_level_q <= rx_level;
            if (rx_sync_b == rx_sync_c)
                rx_level <= rx_sync_c;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_state <= uart_pkg::RX_IDLE;
            rx_shift <= 9'h000;
            rx_par   <= 1'b0;
            rx_idx   <= 4'h0;
            rx_cnt   <= '0;
            rx_acc   <= 3'h0;
        end
        else if (!rx_run)
        begin
            rx_state <= uart_pkg::RX_IDLE;
            rx_acc   <= 3'h0;
        end
        else if (rx_state == uart_pkg::RX_IDLE)
        begin
            if (rx_level_q && !rx_level)
            begin
                rx_state <= uart_pkg::RX_START;
                rx_cnt   <= {2'b00, divisor_value[DIV_W-1:1]};
                rx_idx   <= 4'h0;
            end
        end
        else if (rx_tick)
        begin
            rx_cnt <= rx_len;
            rx_acc <= rx_sum[2:0];
            case (rx_state)
                uart_pkg::RX_START:
                    rx_state <= rx_level ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
                uart_pkg::RX_DATA:
                begin
                    rx_shift <= {rx_level, rx_shift[8:1]};
                    rx_idx   <= rx_idx + 4'h1;
                    if (rx_idx == last_idx)
                        rx_state <= ctrl.parity_on ? uart_pkg::RX_PAR : uart_pkg::RX_STOP;
                end
                uart_pkg::RX_PAR:
                begin
                    rx_par   <= rx_level;
                    rx_state <= uart_pkg::RX_STOP;
                end
                default:
                    rx_state <= uart_pkg::RX_IDLE;
            endcase
        end
        else
            rx_cnt <= rx_cnt - {{DIV_W{1'b0}}, 1'b1};
    end

    // clear first, then set, so a same-cycle event survives the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_data            <= 9'h000;
            rx_fill_count      <= 3'h0;
            rx_data_avail_flag <= 1'b0;
            overrun_flag       <= 1'b0;
            frame_err_flag     <= 1'b0;
            parity_err_flag    <= 1'b0;
            noise_flag         <= 1'b0;
            rx_addr_flag       <= 1'b0;
        end
        else if (!unit_on)
        begin
            rx_fill_count      <= 3'h0;
            rx_data_avail_flag <= 1'b0;
            overrun_flag       <= 1'b0;
            frame_err_flag     <= 1'b0;
            parity_err_flag    <= 1'b0;
            noise_flag         <= 1'b0;
            rx_addr_flag       <= 1'b0;
        end
        else
        begin
            if (rx_clear)
            begin
                rx_fill_count      <= 3'h0;
                rx_data_avail_flag <= 1'b0;
                overrun_flag       <= 1'b0;
                frame_err_flag     <= 1'b0;
                parity_err_flag    <= 1'b0;
                noise_flag         <= 1'b0;
            end
            if (rx_done && (rx_fill_count == 3'h0 || rx_clear))
            begin
                rx_data            <= rx_word;
                rx_fill_count      <= 3'h1;
                rx_data_avail_flag <= 1'b1;
                frame_err_flag     <= ~rx_level;
                parity_err_flag    <= ctrl.parity_on & (rx_par != par_bit(rx_word, ctrl.word_len_nine,
                                                                          ctrl.parity_type_sel));
                rx_addr_flag       <= ctrl.addr_detect_on & rx_msb;
            end
            else if (rx_done)
                overrun_flag <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_oe    <= 1'b0;
            rx_claim <= 1'b0;
            tx_irq   <= 1'b0;
        end
        else
        begin
            tx_oe    <= unit_on & ctrl.tx_path_enable;
            rx_claim <= unit_on & ctrl.rx_path_enable;
            tx_irq   <= unit_on & ctrl.tx_empty_irq_en & tx_buffer_empty_flag;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_frame_end;
        frame_done ##1 1'b1;
    endsequence

    chk_idle_line_high: assert property (tx_is_idle |-> tx_out)
        else $error("tx line low while idle");
    chk_start_bit_low: assert property (tx_state == uart_pkg::TX_START |-> !tx_out)
        else $error("start bit not low");
    chk_stop_bit_high: assert property (tx_state == uart_pkg::TX_STOP |-> tx_out)
        else $error("stop bit not high");
    chk_disable_flags: assert property (!unit_on |=> tx_buffer_empty_flag && tx_idle_flag && !hold_full)
        else $error("disable did not reset flags");
    chk_tx_path_enable_abort: assert property ($fell(tx_run) |=> tx_is_idle && tx_out)
        else $error("tx enable clear did not abort");
    chk_write_ignored: assert property (wr && sel_data && !tx_buffer_empty_flag |=> $stable(hold_word))
        else $error("write accepted while buffer full");
    chk_direct_load: assert property (direct |=> tx_state == uart_pkg::TX_START && tx_buffer_empty_flag)
        else $error("idle write did not start frame");
    chk_hold_reload: assert property (s_frame_end ##0 (hold_full && tx_run)
        |=> tx_state == uart_pkg::TX_START)
        else $error("held word not sent after frame");
    chk_idle_on_done: assert property (frame_done |=> tx_idle_flag)
        else $error("idle flag not set at frame end");
    chk_bit_stretch: assert property (tx_tick && tx_run && !frame_done |=> tx_cnt == $past(tx_len))
        else $error("bit length not reloaded");

endmodule
`default_nettype wire

// [rtl/uart_pkg.sv]
package uart_pkg;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_DIV  = 8'h0c;
    localparam logic [7:0] OFS_FRAC = 8'h10;

    localparam logic [1:0] PAR_EVEN  = 2'h0;
    localparam logic [1:0] PAR_ODD   = 2'h1;
    localparam logic [1:0] PAR_MARK  = 2'h2;
    localparam logic [1:0] PAR_SPACE = 2'h3;

    typedef struct packed {
        logic       tx_empty_irq_en;
        logic       addr_detect_on;
        logic       send_break_ctl;
        logic       tx_ninth_bit;
        logic       two_stop_sel;
        logic [1:0] parity_type_sel;
        logic       parity_on;
        logic       word_len_nine;
        logic       rx_path_enable;
        logic       tx_path_enable;
        logic       serial_unit_on;
    } ctrl_t;

    typedef struct packed {
        logic       rx_addr_flag;
        logic [2:0] rx_fill_count;
        logic       noise_flag;
        logic       parity_err_flag;
        logic       frame_err_flag;
        logic       overrun_flag;
        logic       rx_idle_flag;
        logic       rx_data_avail_flag;
        logic       tx_idle_flag;
        logic       tx_buffer_empty_flag;
    } status_t;

    localparam ctrl_t      CTRL_RST = 12'h000;
    localparam logic [15:0] DIV_RST  = 16'h0000;
    localparam logic [2:0]  FRAC_RST = 3'h0;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'h0,
        TX_START = 3'h1,
        TX_DATA  = 3'h2,
        TX_PAR   = 3'h3,
        TX_STOP  = 3'h4
    } tx_state_t;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'h0,
        RX_START = 3'h1,
        RX_DATA  = 3'h2,
        RX_PAR   = 3'h3,
        RX_STOP  = 3'h4
    } rx_state_t;

endpackage

// [verif/serial_peer.sv]
`timescale 1ns/1ns
`default_nettype none
module serial_peer (
    // clock and line
    input  wire logic        pclk,
    input  wire logic        tx_out,
    // frame shape from the bench
    input  wire logic [15:0] div,
    input  wire logic [3:0]  nbits,
    // results
    output logic             rx_in,
    output logic [9:0]       word,
    output logic             stop_ok,
    output int               count
);
    int i;
    // rx line rests at the pulled-up idle level; this peer never sends
    initial
    begin
        rx_in = 1'b1;
        word = 10'h000;
        stop_ok = 1'b0;
        count = 0;
        forever
        begin
            @(negedge tx_out);
            repeat (div / 2) @(posedge pclk);
            if (tx_out === 1'b0)
            begin
                word = 10'h000;
                for (i = 0; i < nbits; i++)
                begin
                    repeat (div) @(posedge pclk);
                    word[i] = tx_out;
                end
                repeat (div) @(posedge pclk);
                stop_ok = (tx_out === 1'b1);
                count++;
            end
        end
    end
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
    typedef struct packed { logic [7:0] addr; logic [31:0] mask; logic [31:0] exp; logic err; } row_t;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rx_in;
    logic        tx_out;
    logic        tx_oe;
    logic        rx_claim;
    logic        tx_irq;
    logic [3:0]  nbits;
    logic [9:0]  word;
    logic        stop_ok;
    logic [31:0] q;
    logic        e;
    int          count;
    int          base;
    int          mismatches;
    int          checks_done;
    row_t        rows [5];

    uart_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_in(rx_in), .tx_out(tx_out), .tx_oe(tx_oe), .rx_claim(rx_claim), .tx_irq(tx_irq));
    serial_peer peer (.pclk(pclk), .tx_out(tx_out), .div(16'h0010), .nbits(nbits), .rx_in(rx_in),
        .word(word), .stop_ok(stop_ok), .count(count));

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        if (mismatches == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic send(input logic [7:0] d);
        apb(1'b0, uart_pkg::OFS_STAT, 32'h0);
        apb(1'b1, uart_pkg::OFS_DATA, {24'h000000, d});
    endtask

    task automatic wait_frame(input int n);
        while (count < n) @(posedge pclk);
    endtask

    initial
    begin
        mismatches = 0;
        checks_done = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        nbits = 4'h8;
        rows[0] = '{uart_pkg::OFS_CTRL, 32'hffffffff, 32'h0, 1'b0};
        rows[1] = '{uart_pkg::OFS_STAT, 32'h00000003, 32'h3, 1'b0};
        rows[2] = '{uart_pkg::OFS_DIV, 32'h0000ffff, 32'h0, 1'b0};
        rows[3] = '{uart_pkg::OFS_FRAC, 32'h0000000f, 32'h0, 1'b0};
        rows[4] = '{8'h14, 32'h0, 32'h0, 1'b1};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[r])
        begin
            apb(1'b0, rows[r].addr, 32'h0);
            check("reg_read", q & rows[r].mask, rows[r].exp);
            check("reg_err", {31'h0, e}, {31'h0, rows[r].err});
        end
        apb(1'b1, uart_pkg::OFS_DIV, 32'h00000010);
        apb(1'b1, uart_pkg::OFS_CTRL, 32'h00000007);
        // pin enable follows ctrl one cycle later
        @(posedge pclk);
        check("tx_oe_on", {31'h0, tx_oe}, 32'h1);
        check("line_idle", {31'h0, tx_out}, 32'h1);
        base = count;
        // idle write starts at once and leaves the buffer empty
        send(8'ha5);
        apb(1'b0, uart_pkg::OFS_STAT, 32'h0);
        check("empty_after_idle_write", q & 32'h1, 32'h1);
        send(8'h3c);
        apb(1'b0, uart_pkg::OFS_STAT, 32'h0);
        check("empty_after_held_write", q & 32'h1, 32'h0);
        apb(1'b1, uart_pkg::OFS_DATA, 32'h000000ff);
        wait_frame(base + 1);
        check("first_word", {22'h0, word}, 32'h0a5);
        wait_frame(base + 2);
        check("held_word", {22'h0, word}, 32'h03c);
        check("held_stop", {31'h0, stop_ok}, 32'h1);
        repeat (400) @(posedge pclk);
        check("frames_sent", count - base, 32'h2);
        apb(1'b0, uart_pkg::OFS_STAT, 32'h0);
        check("idle_flags", q & 32'h3, 32'h3);
        // two stop bits keep the frame busy one bit longer
        apb(1'b1, uart_pkg::OFS_CTRL, 32'h00000083);
        base = count;
        send(8'h81);
        wait_frame(base + 1);
        check("two_stop_word", {22'h0, word}, 32'h081);
        repeat (12) @(posedge pclk);
        apb(1'b0, uart_pkg::OFS_STAT, 32'h0);
        check("second_stop_busy", q & 32'h2, 32'h0);
        repeat (16) @(posedge pclk);
        apb(1'b0, uart_pkg::OFS_STAT, 32'h0);
        check("second_stop_done", q & 32'h2, 32'h2);
        // parity kinds: even, odd, mark, space on a byte with five ones
        nbits = 4'h9;
        for (int t = 0; t < 4; t++)
        begin
            apb(1'b1, uart_pkg::OFS_CTRL, 32'h00000017 | (t << 5));
            base = count;
            send(8'h5b);
            wait_frame(base + 1);
            check("parity_word", {22'h0, word}, {23'h0, 1'(4'b0101 >> t), 8'h5b});
        end
        apb(1'b1, uart_pkg::OFS_CTRL, 32'h0000010f);
        base = count;
        send(8'h00);
        wait_frame(base + 1);
        check("ninth_bit", {22'h0, word}, 32'h100);
        // tx enable dropped in mid-frame: line must go high and stay
        send(8'h00);
        repeat (40) @(posedge pclk);
        apb(1'b1, uart_pkg::OFS_CTRL, 32'h0000010d);
        repeat (3) @(posedge pclk);
        check("abort_line", {31'h0, tx_out}, 32'h1);
        check("abort_oe", {31'h0, tx_oe}, 32'h0);
        repeat (300) @(posedge pclk);
        apb(1'b1, uart_pkg::OFS_CTRL, 32'h0000010e);
        apb(1'b0, uart_pkg::OFS_CTRL, 32'h0);
        check("ctrl_off", q, 32'h00000108);
        apb(1'b0, uart_pkg::OFS_STAT, 32'h0);
        check("stat_off", q & 32'h3, 32'h3);
        check("pins_off", {30'h0, tx_oe, rx_claim}, 32'h0);
        // empty flag raises the event output while enabled
        apb(1'b1, uart_pkg::OFS_CTRL, 32'h00000803);
        @(posedge pclk);
        check("irq_level", {31'h0, tx_irq}, 32'h1);
        // reset in mid-frame: line returns high and the format reverts
        send(8'h00);
        repeat (20) @(posedge pclk);
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        check("reset_line", {31'h0, tx_out}, 32'h1);
        check("reset_irq", {31'h0, tx_irq}, 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, uart_pkg::OFS_CTRL, 32'h0);
        check("reset_ctrl", q, 32'h0);
        close_out();
    end

    // whole bench needs well under 20000 cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        close_out();
    end
endmodule
`default_nettype wire
